//--- src/pld_macrocell_pkg.sv
package pld_macrocell_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int GROUP_CELLS  = 8;
  localparam int OUT_CELLS    = 16;
  localparam int IN_CELLS     = 24;
  localparam int IN_GROUP     = 4;
  localparam int IN_GROUPS    = 6;
  localparam int SLOTS        = 4;
  localparam int BORROW_SLOTS = 8;
  localparam int NATIVE_A     = 3;
  localparam int NATIVE_B     = 4;
  localparam int BORROW_A     = 6;
  localparam int BORROW_B_LO  = 5;
  localparam int BORROW_B_HI  = 6;
  localparam int B_HI_FIRST   = 12;
  localparam int ADDR_W       = 8;
  localparam int DATA_W       = 16;
  localparam int LANE_W       = 8;
  localparam int SYNC_DEPTH   = 3;

  // ----------------------------------------------------------------
  // offsets inside the configuration i/o window
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_DIR_A  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DIR_B  = 8'h05;
  localparam logic [ADDR_W-1:0] OFS_IN_A   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IN_B   = 8'h19;
  localparam logic [ADDR_W-1:0] OFS_IN_C   = 8'h1A;
  localparam logic [ADDR_W-1:0] OFS_OUT_A  = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_OUT_B  = 8'h21;
  localparam logic [ADDR_W-1:0] OFS_MASK_A = 8'h22;
  localparam logic [ADDR_W-1:0] OFS_MASK_B = 8'h23;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [LANE_W-1:0] MASK_RESET = 8'h00;
  localparam logic [LANE_W-1:0] DIR_RESET  = 8'h00;
  localparam logic [LANE_W-1:0] ZERO_LANE  = 8'h00;

  // control pin bit positions and idle levels
  localparam int CTL_W   = 4;
  localparam int CTL_WR  = 0;
  localparam int CTL_RD  = 1;
  localparam int CTL_AS  = 2;
  localparam int CTL_EXT = 3;
  localparam logic [CTL_W-1:0] CTL_IDLE = 4'h3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    FF_D  = 4'h1,
    FF_T  = 4'h2,
    FF_JK = 4'h4,
    FF_SR = 4'h8
  } flopType_t;

  typedef enum logic [2:0] {
    IN_PASS  = 3'h1,
    IN_LATCH = 3'h2,
    IN_REG   = 3'h4
  } inMode_t;

  typedef enum logic [2:0] {
    OWN_SELF = 3'h1,
    OWN_PREV = 3'h2,
    OWN_NEXT = 3'h4
  } owner_t;

  typedef struct packed {
    flopType_t ffType;
    logic      invert;
    logic      useReg;
    logic      clkExt;
    logic      oeAlways;
    logic      internalNode;
  } outCfg_t;

  typedef struct packed {
    logic       clkPt;
    logic       presetPt;
    logic [1:0] clrPt;
    logic       kPt;
    logic       oePt;
  } cellTerms_t;

  typedef struct packed {
    logic              sel;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } hostSample_t;

endpackage

//--- src/output_cell.sv
`timescale 1ns/10ps
module output_cell #(
  parameter int NATIVE     = 4,
  parameter int BORROW_MAX = 6
) (
  // clock and reset
  input  wire logic                             clk,
  input  wire logic                             reset,
  // configuration and product terms
  input  pld_macrocell_pkg::outCfg_t            cfg,
  input  pld_macrocell_pkg::cellTerms_t         ctl,
  input  wire logic [NATIVE-1:0]                ownTerms,
  input  wire logic [7:0]                       borrowVal,
  input  wire logic [7:0]                       borrowGrant,
  input  wire logic                             extEdge,
  // host side
  input  wire logic                             hostLoad,
  input  wire logic                             hostBit,
  input  wire logic                             dirBit,
  // results
  output logic                                  pinOut,
  output logic                                  pinOe,
  output logic                                  feedback,
  output logic                                  flopQ
);
  import pld_macrocell_pkg::*;

  logic sum;
  logic borrowed;
  logic logicVal;
  logic clkPrev_q;
  logic clkEvent;
  logic clear;
  logic q_q;
  logic selVal;

  // ---------------
  // product term allocator
  // ---------------
  // grants past the budget are dropped in slot order
  always_comb begin
    int taken;
    taken = 0;
    borrowed = 1'b0;
    for (int i = 0; i < BORROW_SLOTS; i++) begin
      if (borrowGrant[i] && taken < BORROW_MAX) begin
        borrowed = borrowed | borrowVal[i];
        taken = taken + 1;
      end
    end
  end

  assign sum      = (|ownTerms) | borrowed;
  assign logicVal = sum ^ cfg.invert;

  // ---------------
  // storage element
  // ---------------
  always_ff @(posedge clk) begin
    if (reset) begin
      clkPrev_q <= 1'b0;
    end else begin
      clkPrev_q <= ctl.clkPt;
    end
  end

  assign clkEvent = cfg.clkExt ? extEdge : (ctl.clkPt & ~clkPrev_q);
  assign clear    = |ctl.clrPt;

  // host load first, then clear over preset
  always_ff @(posedge clk) begin
    if (reset) begin
      q_q <= 1'b0;
    end else if (hostLoad) begin
      q_q <= hostBit;
    end else if (clear) begin
      q_q <= 1'b0;
    end else if (ctl.presetPt) begin
      q_q <= 1'b1;
    end else if (clkEvent) begin
      case (cfg.ffType)
        FF_D:    q_q <= logicVal;
        FF_T:    q_q <= q_q ^ logicVal;
        FF_JK:   q_q <= (logicVal & ~q_q) | (~ctl.kPt & q_q);
        FF_SR:   q_q <= logicVal | (~ctl.kPt & q_q);
        default: q_q <= q_q;
      endcase
    end
  end

  // ---------------
  // output path
  // ---------------
  assign selVal   = cfg.useReg ? q_q : logicVal;
  assign pinOut   = selVal;
  assign feedback = selVal;
  assign flopQ    = q_q;

  always_comb begin
    if (cfg.internalNode) begin
      pinOe = 1'b0;
    end else if (cfg.oeAlways) begin
      pinOe = 1'b1;
    end else begin
      pinOe = ctl.oePt | dirBit;
    end
  end

endmodule

//--- src/input_cell.sv
`timescale 1ns/10ps
module input_cell (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset,
  // pins and configuration
  input  wire logic [3:0]                  pinIn,
  input  pld_macrocell_pkg::inMode_t [3:0] mode,
  input  wire logic                        enSel,
  input  wire logic                        enPt,
  input  wire logic                        addrStrobe,
  // logic input bus
  output logic [3:0]                       cellOut
);
  import pld_macrocell_pkg::*;

  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] pin_q;
  logic [3:0] held_q;
  logic       enPrev_q;
  logic       enable;
  logic       enRise;

  // ---------------
  // pin capture
  // ---------------
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      pin_q <= '0;
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < IN_GROUP; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          pin_q[i] <= s3_q[i];
        end
      end
    end
  end

  // ---------------
  // latch and register
  // ---------------
  // one enable for all four cells of the group
  assign enable = enSel ? addrStrobe : enPt;
  assign enRise = enable & ~enPrev_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      enPrev_q <= 1'b0;
      held_q   <= '0;
    end else begin
      enPrev_q <= enable;
      for (int i = 0; i < IN_GROUP; i++) begin
        if (mode[i] == IN_LATCH && enable) begin
          held_q[i] <= pin_q[i];
        end else if (mode[i] == IN_REG && enRise) begin
          held_q[i] <= pin_q[i];
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < IN_GROUP; i++) begin
      cellOut[i] = (mode[i] == IN_PASS) ? pin_q[i] : held_q[i];
    end
  end

endmodule

//--- src/pld_macrocell_array.sv
// Contract
// - sixteen output cells, eight each port
// - xor stage sets output polarity
// - register or combinational to pin, feedback
// - flop works as D, T, JK, SR
// - flop clock: product term or external pin
// - preset, clear high; clear two terms
// - fixed data lanes, endian swap, 8-bit
// - native and borrow budgets per cell
// - borrow neighbours only, terms never shared
// - wide equations chain through cell feedback
// - host load overrides flop, reads back
// - data captured at write strobe end
// - per cell mask bit blocks host writes
// - pin enable is term or direction
// - no enable equation: input from reset
// - internal node frees pin, keeps feedback
// - 24 input cells: latch, register, pass
// - enable from term or address strobe
// - address strobe captures high address bits
// - second processor mailbox via port terms
// - block decoded inside config window
// - cells sit on the internal data bus
`timescale 1ns/10ps
module pld_macrocell_array (
  // clock and reset
  input  wire logic                                 clk,
  input  wire logic                                 reset,
  // host bus
  input  wire logic                                 configIoWindow,
  input  wire logic [pld_macrocell_pkg::ADDR_W-1:0] hostAddr,
  input  wire logic [pld_macrocell_pkg::DATA_W-1:0] hostDataIn,
  input  wire logic                                 hostWrLowStrobeN,
  input  wire logic                                 hostRdStrobeN,
  input  wire logic                                 hostAddressStrobe,
  input  wire logic                                 busIs16,
  input  wire logic                                 busBigEndian,
  output logic [pld_macrocell_pkg::DATA_W-1:0]      hostDataOut,
  output logic                                      hostDataOe,
  // and array side
  input  wire logic [15:0][3:0]                     termIn,
  input  pld_macrocell_pkg::owner_t [15:0][3:0]     termOwner,
  input  pld_macrocell_pkg::cellTerms_t [15:0]      cellTerms,
  input  pld_macrocell_pkg::outCfg_t [15:0]         outCfg,
  input  pld_macrocell_pkg::inMode_t [23:0]         inMode,
  input  wire logic [5:0]                           inEnSel,
  input  wire logic [5:0]                           inEnPt,
  output logic [15:0]                               cellFeedback,
  output logic [23:0]                               inputBus,
  // pins
  input  wire logic                                 externalFlopClock,
  input  wire logic [7:0]                           portAIn,
  input  wire logic [7:0]                           portBIn,
  input  wire logic [7:0]                           portCIn,
  output logic [7:0]                                portAOut,
  output logic [7:0]                                portAOe,
  output logic [7:0]                                portBOut,
  output logic [7:0]                                portBOe
);
  import pld_macrocell_pkg::*;

  logic [CTL_W-1:0]  ctlPins;
  logic [CTL_W-1:0]  c1_q;
  logic [CTL_W-1:0]  c2_q;
  logic [CTL_W-1:0]  c3_q;
  logic [CTL_W-1:0]  lvl_q;
  logic [CTL_W-1:0]  rise;
  hostSample_t       sample_q [SYNC_DEPTH];
  hostSample_t       held_q;
  logic              wrHit;
  logic              rdActive;
  logic [7:0]        maskA_q;
  logic [7:0]        maskB_q;
  logic [7:0]        dirA_q;
  logic [7:0]        dirB_q;
  logic [7:0]        laneLo;
  logic [7:0]        laneHi;
  logic              goA;
  logic              goB;
  logic [7:0]        valA;
  logic [7:0]        valB;
  logic [15:0]       hostLoad;
  logic [15:0]       hostBit;
  logic [15:0]       dirBits;
  logic [15:0]       cellOut;
  logic [15:0]       cellOe;
  logic [15:0]       flopQ;
  logic [15:0][3:0]  ownVal;
  logic [15:0][7:0]  bVal;
  logic [15:0][7:0]  bGrant;
  logic [23:0]       pinsAll;
  logic [15:0]       rdData_q;
  logic              rdMapped;
  logic [15:0]       rdNext;

  // ---------------
  // control pin capture
  // ---------------
  assign ctlPins[CTL_WR]  = hostWrLowStrobeN;
  assign ctlPins[CTL_RD]  = hostRdStrobeN;
  assign ctlPins[CTL_AS]  = hostAddressStrobe;
  assign ctlPins[CTL_EXT] = externalFlopClock;

  always_ff @(posedge clk) begin
    if (reset) begin
      c1_q  <= CTL_IDLE;
      c2_q  <= CTL_IDLE;
      c3_q  <= CTL_IDLE;
      lvl_q <= CTL_IDLE;
    end else begin
      c1_q <= ctlPins;
      c2_q <= c1_q;
      c3_q <= c2_q;
      for (int i = 0; i < CTL_W; i++) begin
        if (c2_q[i] == c3_q[i]) begin
          lvl_q[i] <= c3_q[i];
        end
      end
    end
  end

  // a rising level counts only once two stages agree
  assign rise     = c2_q & c3_q & ~lvl_q;
  assign rdActive = ~lvl_q[CTL_RD];

  // ---------------
  // write sampling
  // ---------------
  // bus words travel beside the strobe stages, so the copy kept is
  // the last one seen while the strobe was still low at the pins
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < SYNC_DEPTH; i++) begin
        sample_q[i] <= '0;
      end
    end else begin
      sample_q[0] <= '{configIoWindow, hostAddr, hostDataIn};
      for (int i = 1; i < SYNC_DEPTH; i++) begin
        sample_q[i] <= sample_q[i-1];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      held_q <= '0;
    end else if (!c3_q[CTL_WR]) begin
      held_q <= sample_q[SYNC_DEPTH-1];
    end
  end

  // trailing edge of the write strobe
  assign wrHit  = rise[CTL_WR] & held_q.sel;
  assign laneLo = held_q.data[LANE_W-1:0];
  assign laneHi = held_q.data[DATA_W-1:LANE_W];

  // ---------------
  // mask and direction registers
  // ---------------
  always_ff @(posedge clk) begin
    if (reset) begin
      maskA_q <= MASK_RESET;
      maskB_q <= MASK_RESET;
    end else if (wrHit && held_q.addr == OFS_MASK_A) begin
      maskA_q <= laneLo;
    end else if (wrHit && held_q.addr == OFS_MASK_B) begin
      maskB_q <= laneLo;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      dirA_q <= DIR_RESET;
      dirB_q <= DIR_RESET;
    end else if (wrHit && held_q.addr == OFS_DIR_A) begin
      dirA_q <= laneLo;
    end else if (wrHit && held_q.addr == OFS_DIR_B) begin
      dirB_q <= laneLo;
    end
  end

  // ---------------
  // output cell loading
  // ---------------
  always_comb begin
    goA  = 1'b0;
    goB  = 1'b0;
    valA = laneLo;
    valB = laneLo;
    if (wrHit && held_q.addr == OFS_OUT_A) begin
      goA = 1'b1;
      if (busIs16) begin
        goB  = 1'b1;
        valA = busBigEndian ? laneHi : laneLo;
        valB = busBigEndian ? laneLo : laneHi;
      end
    end else if (wrHit && held_q.addr == OFS_OUT_B) begin
      goB = 1'b1;
    end
  end

  // a set mask bit shields a cell that logic owns
  assign hostLoad = {{8{goB}} & ~maskB_q, {8{goA}} & ~maskA_q};
  assign hostBit  = {valB, valA};
  assign dirBits  = {dirB_q, dirA_q};

  // ---------------
  // product term ownership
  // ---------------
  // a term has exactly one owner, so it can never serve two cells
  for (genvar k = 0; k < OUT_CELLS; k++) begin : g_route
    localparam int NK = (k < GROUP_CELLS) ? NATIVE_A : NATIVE_B;
    localparam int NL = (k - 1 < GROUP_CELLS) ? NATIVE_A : NATIVE_B;
    localparam int NH = (k + 1 < GROUP_CELLS) ? NATIVE_A : NATIVE_B;
    for (genvar j = 0; j < SLOTS; j++) begin : g_slot
      assign ownVal[k][j] = (j < NK) && termIn[k][j] &&
                            termOwner[k][j] == OWN_SELF;
      if (k > 0) begin : g_lo
        assign bVal[k][j]   = termIn[k-1][j];
        assign bGrant[k][j] = (j < NL) &&
                              termOwner[k-1][j] == OWN_NEXT;
      end else begin : g_lo0
        assign bVal[k][j]   = 1'b0;
        assign bGrant[k][j] = 1'b0;
      end
      if (k < OUT_CELLS - 1) begin : g_hi
        assign bVal[k][j+SLOTS]   = termIn[k+1][j];
        assign bGrant[k][j+SLOTS] = (j < NH) &&
                                    termOwner[k+1][j] == OWN_PREV;
      end else begin : g_hi0
        assign bVal[k][j+SLOTS]   = 1'b0;
        assign bGrant[k][j+SLOTS] = 1'b0;
      end
    end
  end

  // ---------------
  // output cells
  // ---------------
  for (genvar k = 0; k < OUT_CELLS; k++) begin : g_out
    localparam int NK = (k < GROUP_CELLS) ? NATIVE_A : NATIVE_B;
    localparam int BK = (k < GROUP_CELLS) ? BORROW_A :
                        (k < B_HI_FIRST) ? BORROW_B_LO : BORROW_B_HI;
    output_cell #(
      .NATIVE     (NK),
      .BORROW_MAX (BK)
    ) u_cell (
      .clk         (clk),
      .reset       (reset),
      .cfg         (outCfg[k]),
      .ctl         (cellTerms[k]),
      .ownTerms    (ownVal[k][NK-1:0]),
      .borrowVal   (bVal[k]),
      .borrowGrant (bGrant[k]),
      .extEdge     (rise[CTL_EXT]),
      .hostLoad    (hostLoad[k]),
      .hostBit     (hostBit[k]),
      .dirBit      (dirBits[k]),
      .pinOut      (cellOut[k]),
      .pinOe       (cellOe[k]),
      .feedback    (cellFeedback[k]),
      .flopQ       (flopQ[k])
    );
  end

  // feedback lets wide equations expand through spare cells
  // at the cost of one more pass through the array
  assign portAOut = cellOut[7:0];
  // second processor reads when its read term opens port a
  assign portAOe  = cellOe[7:0];
  assign portBOut = cellOut[15:8];
  assign portBOe  = cellOe[15:8];

  // ---------------
  // input cells
  // ---------------
  assign pinsAll = {portCIn, portBIn, portAIn};

  for (genvar g = 0; g < IN_GROUPS; g++) begin : g_in
    input_cell u_in (
      .clk        (clk),
      .reset      (reset),
      .pinIn      (pinsAll[g*IN_GROUP +: IN_GROUP]),
      .mode       (inMode[g*IN_GROUP +: IN_GROUP]),
      .enSel      (inEnSel[g]),
      .enPt       (inEnPt[g]),
      .addrStrobe (lvl_q[CTL_AS]),
      .cellOut    (inputBus[g*IN_GROUP +: IN_GROUP])
    );
  end

  // ---------------
  // host reads
  // ---------------
  // pure selection: nothing here touches cell state
  always_comb begin
    rdMapped = 1'b1;
    rdNext   = '0;
    case (hostAddr)
      OFS_OUT_A: begin
        if (!busIs16) begin
          rdNext = {ZERO_LANE, flopQ[7:0]};
        end else if (busBigEndian) begin
          rdNext = {flopQ[7:0], flopQ[15:8]};
        end else begin
          rdNext = flopQ;
        end
      end
      OFS_OUT_B:  rdNext = {ZERO_LANE, flopQ[15:8]};
      OFS_MASK_A: rdNext = {ZERO_LANE, maskA_q};
      OFS_MASK_B: rdNext = {ZERO_LANE, maskB_q};
      OFS_DIR_A:  rdNext = {ZERO_LANE, dirA_q};
      OFS_DIR_B:  rdNext = {ZERO_LANE, dirB_q};
      OFS_IN_A:   rdNext = {ZERO_LANE, inputBus[7:0]};
      OFS_IN_B:   rdNext = {ZERO_LANE, inputBus[15:8]};
      OFS_IN_C:   rdNext = {ZERO_LANE, inputBus[23:16]};
      default:    rdMapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdData_q <= '0;
    end else begin
      rdData_q <= rdNext;
    end
  end

  // unmapped addresses leave the bus undriven
  assign hostDataOut = rdData_q;
  assign hostDataOe  = rdActive & configIoWindow & rdMapped;

endmodule

//--- tb/pld_macrocell_array_properties.sv
`timescale 1ns/10ps
module pld_macrocell_array_properties (
  // clock, reset, host bus
  input wire logic           clk,
  input wire logic           reset,
  input wire logic           configIoWindow,
  input wire logic [7:0]     hostAddr,
  input wire logic           hostWrLowStrobeN,
  input wire logic           hostRdStrobeN,
  input wire logic [15:0]    hostDataOut,
  input wire logic           hostDataOe,
  // cells and pins
  input wire logic [15:0][3:0]                termIn,
  input pld_macrocell_pkg::cellTerms_t [15:0] cellTerms,
  input pld_macrocell_pkg::outCfg_t [15:0]    outCfg,
  input wire logic           externalFlopClock,
  input wire logic [15:0]    cellFeedback,
  input wire logic [7:0]     portAOut,
  input wire logic [7:0]     portAOe
);
  import pld_macrocell_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_window_gate: assert property (!configIoWindow |-> !hostDataOe)
    else $error("read enable outside window");
  a_read_idle: assert property (hostRdStrobeN [*5] |-> !hostDataOe)
    else $error("read enable without strobe");
  a_read_answer: assert property (($fell(hostRdStrobeN) ##1 (!hostRdStrobeN
    && configIoWindow && hostAddr == OFS_OUT_A) [*4]) |-> hostDataOe)
    else $error("read enable late");
  a_mask_upper: assert property (hostDataOe && hostAddr == OFS_MASK_A
    && $stable(hostAddr) |-> hostDataOut[15:8] == 8'h00)
    else $error("mask upper byte not zero");
  a_comb_polarity: assert property (!outCfg[0].useReg
    && !outCfg[0].internalNode && termIn == '0
    |-> portAOut[0] == outCfg[0].invert)
    else $error("polarity wrong");
  a_feedback_pin: assert property (!outCfg[0].internalNode
    |-> cellFeedback[0] == portAOut[0])
    else $error("feedback differs from pin");
  a_oe_always: assert property (outCfg[1].oeAlways
    && !outCfg[1].internalNode |-> portAOe[1])
    else $error("pin not driven");
  a_node_free: assert property (outCfg[2].internalNode |-> !portAOe[2])
    else $error("internal node drives pin");
  a_clear_wins: assert property ((outCfg[0].useReg
    && cellTerms[0].clrPt != 2'b00 && hostWrLowStrobeN) [*7] |-> !portAOut[0])
    else $error("clear ignored");
  a_ext_hold: assert property ((outCfg[0].useReg && outCfg[0].clkExt
    && cellTerms[0] == '0 && !externalFlopClock && hostWrLowStrobeN) [*7]
    |-> $stable(portAOut[0]))
    else $error("flop moved without edge");
endmodule

//--- tb/host_bus_model.sv
`timescale 1ns/10ps
module host_bus_model (
  // clock and answers
  input  wire logic        clk,
  input  wire logic [15:0] hostDataOut,
  input  wire logic        hostDataOe,
  // bus requests
  output logic             configIoWindow,
  output logic [7:0]       hostAddr,
  output logic [15:0]      hostDataIn,
  output logic             hostWrLowStrobeN,
  output logic             hostRdStrobeN
);
  initial begin
    {configIoWindow, hostAddr, hostDataIn} = {1'b0, 8'hFF, 16'h0000};
    {hostWrLowStrobeN, hostRdStrobeN} = 2'b11;
  end
  // data stays up well past strobe end; released bus shows inverse
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) #1 {configIoWindow, hostAddr, hostDataIn} = {1'b1, a, d};
    hostWrLowStrobeN = 1'b0;
    repeat (4) @(posedge clk);
    #1 hostWrLowStrobeN = 1'b1;
    repeat (5) @(posedge clk);
    #1 {configIoWindow, hostDataIn} = {1'b0, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [16:0] d);
    @(posedge clk) #1 {configIoWindow, hostAddr} = {1'b1, a};
    hostRdStrobeN = 1'b0;
    repeat (8) if (hostDataOe !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    d = {hostDataOe, hostDataOut};
    @(posedge clk) #1 hostRdStrobeN = 1'b1;
    repeat (4) @(posedge clk);
    #1 configIoWindow = 1'b0;
  endtask
endmodule

//--- tb/pld_macrocell_array_tb.sv
`timescale 1ns/10ps
module pld_macrocell_array_tb;
  import pld_macrocell_pkg::*;
  logic               clk, reset, configIoWindow, hostWrLowStrobeN;
  logic               hostRdStrobeN, hostAddressStrobe, busIs16;
  logic               busBigEndian, hostDataOe, externalFlopClock;
  logic [7:0]         hostAddr, portAIn, portBIn, portCIn;
  logic [7:0]         portAOut, portAOe, portBOut, portBOe;
  logic [15:0]        hostDataIn, hostDataOut, cellFeedback;
  logic [23:0]        inputBus;
  logic [15:0][3:0]   termIn;
  owner_t [15:0][3:0] termOwner;
  cellTerms_t [15:0]  cellTerms;
  outCfg_t [15:0]     outCfg;
  inMode_t [23:0]     inMode;
  logic [5:0]         inEnSel, inEnPt;
  logic [16:0]        r;
  int                 errors, nChecks;
  flopType_t          ty [4] = '{FF_D, FF_T, FF_JK, FF_SR};

  pld_macrocell_array i_pld_macrocell_array (.clk, .reset, .configIoWindow,
    .hostAddr, .hostDataIn, .hostWrLowStrobeN, .hostRdStrobeN,
    .hostAddressStrobe, .busIs16, .busBigEndian, .hostDataOut, .hostDataOe,
    .termIn, .termOwner, .cellTerms, .outCfg, .inMode, .inEnSel, .inEnPt,
    .cellFeedback, .inputBus, .externalFlopClock, .portAIn, .portBIn,
    .portCIn, .portAOut, .portAOe, .portBOut, .portBOe);
  host_bus_model i_host_bus_model (.clk, .hostDataOut, .hostDataOe,
    .configIoWindow, .hostAddr, .hostDataIn, .hostWrLowStrobeN,
    .hostRdStrobeN);

  task automatic check(input string what, input logic [23:0] exp, got);
    nChecks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_regs;
    i_host_bus_model.rd(OFS_MASK_A, r);
    check("maskA", 17'h10000, r);
    i_host_bus_model.rd(OFS_MASK_B, r);
    check("maskB", 17'h10000, r);
    i_host_bus_model.rd(8'h7F, r);
    check("unmapped", 17'h00000, r);
    $display("regs done");
  endtask
  task automatic t_lanes;
    i_host_bus_model.wr(OFS_OUT_A, 16'hA55A);
    check("lanes", 16'hA55A, {portBOut, portAOut});
    i_host_bus_model.rd(OFS_OUT_A, r);
    check("readback", 17'h1A55A, r);
    busBigEndian = 1'b1;
    i_host_bus_model.wr(OFS_OUT_A, 16'h1234);
    check("swap", 16'h3412, {portBOut, portAOut});
    i_host_bus_model.rd(OFS_OUT_A, r);
    check("swapread", 17'h11234, r);
    {busBigEndian, busIs16} = 2'b00;
    i_host_bus_model.wr(OFS_OUT_A, 16'hFF3C);
    check("byte", 16'h343C, {portBOut, portAOut});
    busIs16 = 1'b1;
    i_host_bus_model.wr(OFS_MASK_A, 16'h000F);
    i_host_bus_model.wr(OFS_OUT_A, 16'h00C3);
    check("masked", 8'hCC, portAOut);
    i_host_bus_model.wr(OFS_MASK_A, 16'h0000);
    $display("lanes done");
  endtask
  task automatic t_flop;
    cellTerms[0].clrPt = 2'b01;
    cellTerms[0].presetPt = 1'b1;
    wt(8);
    check("clear", 1'b0, portAOut[0]);
    cellTerms[0].clrPt = 2'b00;
    wt(8);
    check("preset", 1'b1, portAOut[0]);
    {cellTerms[0], termIn[0], outCfg[0].clkExt} = {6'h02, 4'h1, 1'b1};
    for (int i = 0; i < 4; i++) begin
      outCfg[0].ffType = ty[i];
      cellTerms[0].clrPt = 2'b10;
      wt(8);
      cellTerms[0].clrPt = 2'b00;
      repeat (2) begin
        externalFlopClock = 1'b1;
        wt(4);
        externalFlopClock = 1'b0;
        wt(4);
      end
      check("ftype", i == 0 || i == 3, portAOut[0]);
    end
    {cellTerms[0], termIn[0], outCfg[0].ffType} = {6'h00, 4'h0, FF_D};
    wt(8);
    $display("flop done");
  endtask
  task automatic t_comb;
    outCfg[0].useReg = 1'b0;
    for (int v = 0; v < 2; v++) begin
      outCfg[0].invert = v[0];
      termIn[0] = 4'h0;
      wt(1);
      check("pol", v[0], portAOut[0]);
      termIn[0] = 4'h2;
      wt(1);
      check("feedback", !v[0], cellFeedback[0]);
    end
    {outCfg[0].useReg, outCfg[0].invert, termIn[0]} = {2'b10, 4'h0};
    i_host_bus_model.wr(OFS_DIR_A, 16'h0001);
    {outCfg[1].oeAlways, outCfg[2].oeAlways, outCfg[2].internalNode} = 3'h7;
    wt(1);
    check("enables", 16'h0003, {portBOe, portAOe});
    $display("comb done");
  endtask
  task automatic t_in;
    {portCIn, portBIn, portAIn} = 24'hC3B2A1;
    wt(6);
    check("pass", 24'hC3B2A1, inputBus);
    i_host_bus_model.rd(OFS_IN_C, r);
    check("inread", 17'h100C3, r);
    inEnSel = 6'h30;
    for (int k = 16; k < 24; k++) inMode[k] = IN_LATCH;
    hostAddressStrobe = 1'b1;
    wt(6);
    hostAddressStrobe = 1'b0;
    wt(6);
    portCIn = 8'h5E;
    wt(6);
    check("latch", 8'hC3, inputBus[23:16]);
    $display("input done");
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #50us;
    errors++;
    print_verdict;
  end
  initial begin
    {reset, busIs16, busBigEndian, hostAddressStrobe} = 4'hC;
    {externalFlopClock, portAIn, portBIn, portCIn} = '0;
    {termIn, cellTerms, inEnSel, inEnPt} = '0;
    for (int k = 0; k < 24; k++) inMode[k] = IN_PASS;
    for (int k = 0; k < 16; k++) begin
      outCfg[k] = '{FF_D, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
      for (int j = 0; j < 4; j++) termOwner[k][j] = OWN_SELF;
    end
    wt(4);
    reset = 1'b0;
    t_regs;
    t_lanes;
    t_flop;
    t_comb;
    t_in;
    print_verdict;
  end
endmodule

bind pld_macrocell_array pld_macrocell_array_properties i_props (.clk,
  .reset, .configIoWindow, .hostAddr, .hostWrLowStrobeN, .hostRdStrobeN,
  .hostDataOut, .hostDataOe, .termIn, .cellTerms, .outCfg,
  .externalFlopClock, .cellFeedback, .portAOut, .portAOe);
